// ===== rtl/time_base_irq_pkg.sv
// constants for the time base and interrupt block
// assumes one 50 MHz clock and word-aligned AHB-Lite register access
package time_base_irq_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
  localparam int DIV4_RATIO = 4;
  localparam int PERIOD_W = 3;
  localparam int CNT_W = 15;
  localparam int BASE_EXP = 8;
  localparam int TB_EN_BIT = 7;
  localparam int NUM_FLAGS = 3;
  localparam int NUM_EVTS = 4;
  // register byte offsets
  localparam logic [7:0] TB0_CTRL_OFS = 8'h00;
  localparam logic [7:0] TB1_CTRL_OFS = 8'h04;
  localparam logic [7:0] PSC_SEL_OFS = 8'h08;
  localparam logic [7:0] INT_CTRL_OFS = 8'h0c;
  localparam logic [7:0] FLAGS_OFS = 8'h10;
  localparam logic [7:0] EVT_STAT_OFS = 8'h14;
  localparam logic [7:0] EVT_MASK_OFS = 8'h18;
  // reset values
  localparam logic [7:0] TB_CTRL_RST = 8'h00;
  localparam logic [1:0] PSC_SEL_RST = 2'h0;
  localparam logic [5:0] INT_CTRL_RST = 6'h00;
  localparam logic [2:0] FLAGS_RST = 3'h0;
  localparam logic [3:0] EVT_RST = 4'h0;
  // interrupt control fields
  localparam int GIE_BIT = 0;
  localparam int TB0_IE_BIT = 1;
  localparam int TB1_IE_BIT = 2;
  localparam int EXT_IE_BIT = 3;
  localparam int EDGE_LSB = 4;
  // flag positions, also the priority order (lowest index first)
  localparam int FLG_EXT = 0;
  localparam int FLG_TB0 = 1;
  localparam int FLG_TB1 = 2;
  localparam int EVT_WAKE = 3;
  // prescaler source codes
  localparam logic [1:0] PSC_SYS = 2'h0;
  localparam logic [1:0] PSC_DIV4 = 2'h1;
  localparam int PSC_SUB_BIT = 1;
  localparam int PC_W = 10;
endpackage

// ===== rtl/pin_sync.sv
// two flip-flop synchroniser for one pin
// assumes the pin is asynchronous to ref_clk
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // pin and result
  input wire logic pinIn,
  output logic pinSync
);
  logic stage1_ff;
  logic stage2_ff;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1_ff <= 1'b0;
      stage2_ff <= 1'b0;
    end else begin
      stage1_ff <= pinIn;
      stage2_ff <= stage1_ff;
    end
  end
  assign pinSync = stage2_ff;
endmodule

// ===== rtl/tbase_divider.sv
// one time base divider with selectable time-out
// assumes tick is a one-cycle prescaled clock enable
`timescale 1ns/1ps
module tbase_divider (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic tick,
  input wire logic enable,
  input wire logic [time_base_irq_pkg::PERIOD_W-1:0] periodSel,
  // event
  output logic overflow
);
  import time_base_irq_pkg::*;
  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] nxt_count;
  logic [CNT_W-1:0] lastCount;
  logic ovf_ff;
  logic hit;
  // last count is 2^(8+n)-1, code 110 taken as 2^14
  assign lastCount = CNT_W'((32'h1 << (BASE_EXP + 32'(periodSel))) - 32'h1);
  assign hit = enable && tick && (count_ff == lastCount);
  assign nxt_count = !enable ? '0 : hit ? '0 : tick ? count_ff + 1'b1 : count_ff;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_ff <= '0;
      ovf_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      ovf_ff <= hit;
    end
  end
  assign overflow = ovf_ff;
endmodule

// ===== rtl/time_base_irq_wakeup.sv
// time bases, interrupt flags, wake-up and global enable control
// assumes an AHB-Lite master and core logic on ref_clk; pins are asynchronous
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module time_base_irq_wakeup (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // pins
  input wire logic extIntPin,
  input wire logic subClkPin,
  // core side
  input wire logic sleepMode,
  input wire logic instrBoundary,
  input wire logic stackFull,
  input wire logic [time_base_irq_pkg::PC_W-1:0] pcNow,
  input wire logic interruptExitOp,
  input wire logic subroutineExitOp,
  output logic irqEntry,
  output logic [1:0] irqVector,
  output logic stackPush,
  output logic [time_base_irq_pkg::PC_W-1:0] stackPushData,
  output logic wakeUp,
  output logic irq
);
  import time_base_irq_pkg::*;

  logic [PERIOD_W:0] tb0Ctrl_ff;
  logic [PERIOD_W:0] tb1Ctrl_ff;
  logic [1:0] pscSel_ff;
  logic [5:0] intCtrl_ff;
  logic [NUM_FLAGS-1:0] flags_ff;
  logic [NUM_FLAGS-1:0] flagsPrev_ff;
  logic [NUM_EVTS-1:0] evtStatus_ff;
  logic [NUM_EVTS-1:0] evtMask_ff;
  logic [1:0] div4_ff;
  logic subPrev_ff;
  logic extPrev_ff;
  logic wrPend_ff;
  logic [7:0] wrAddr_ff;
  logic hreadyout_ff;
  logic [31:0] hrdata_ff;
  logic irqEntry_ff;
  logic [1:0] irqVector_ff;
  logic stackPush_ff;
  logic [PC_W-1:0] stackPushData_ff;
  logic wakeUp_ff;
  logic irq_ff;

  logic [PERIOD_W:0] nxt_tb0Ctrl;
  logic [PERIOD_W:0] nxt_tb1Ctrl;
  logic [1:0] nxt_pscSel;
  logic [5:0] nxt_intCtrl;
  logic [NUM_FLAGS-1:0] nxt_flags;
  logic [NUM_EVTS-1:0] nxt_evtStatus;
  logic [NUM_EVTS-1:0] nxt_evtMask;
  logic [31:0] nxt_hrdata;

  logic extSync;
  logic subSync;
  logic subRise;
  logic extRise;
  logic extFall;
  logic extEdge;
  logic pscTick;
  logic tb0Ovf;
  logic tb1Ovf;
  logic addrPhase;
  logic [7:0] rdAddr;
  logic wrTb0;
  logic wrTb1;
  logic wrPsc;
  logic wrInt;
  logic wrFlags;
  logic wrStat;
  logic wrMask;
  logic [NUM_FLAGS-1:0] enables;
  logic [NUM_FLAGS-1:0] pending;
  logic take;
  logic [1:0] takeSel;
  logic [NUM_FLAGS-1:0] serviceClr;
  logic [NUM_FLAGS-1:0] flagSet;
  logic [NUM_FLAGS-1:0] flagRise;
  logic [NUM_EVTS-1:0] evtSet;
  logic plainExit;

  // pin synchronisers
  pin_sync extSyncInst (
    .ref_clk(ref_clk),
    .rst(rst),
    .pinIn(extIntPin),
    .pinSync(extSync)
  );
  pin_sync subSyncInst (
    .ref_clk(ref_clk),
    .rst(rst),
    .pinIn(subClkPin),
    .pinSync(subSync)
  );

  // prescaler source select
  assign subRise = subSync && !subPrev_ff;
  assign pscTick = pscSel_ff[PSC_SUB_BIT] ? subRise :
                   (pscSel_ff == PSC_SYS) ? 1'b1 : (div4_ff == 2'(DIV4_RATIO - 1));

  tbase_divider tb0Inst (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(pscTick),
    .enable(tb0Ctrl_ff[PERIOD_W]),
    .periodSel(tb0Ctrl_ff[PERIOD_W-1:0]),
    .overflow(tb0Ovf)
  );
  tbase_divider tb1Inst (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(pscTick),
    .enable(tb1Ctrl_ff[PERIOD_W]),
    .periodSel(tb1Ctrl_ff[PERIOD_W-1:0]),
    .overflow(tb1Ovf)
  );

  // external edge detect, edge select 01 rise, 10 fall, 11 both, 00 off
  assign extRise = extSync && !extPrev_ff;
  assign extFall = !extSync && extPrev_ff;
  assign extEdge = (intCtrl_ff[EDGE_LSB] && extRise) || (intCtrl_ff[EDGE_LSB+1] && extFall);

  // bus decode
  assign addrPhase = hsel && htrans[1] && hready;
  assign rdAddr = haddr[7:0];
  assign wrTb0 = wrPend_ff && (wrAddr_ff == TB0_CTRL_OFS);
  assign wrTb1 = wrPend_ff && (wrAddr_ff == TB1_CTRL_OFS);
  assign wrPsc = wrPend_ff && (wrAddr_ff == PSC_SEL_OFS);
  assign wrInt = wrPend_ff && (wrAddr_ff == INT_CTRL_OFS);
  assign wrFlags = wrPend_ff && (wrAddr_ff == FLAGS_OFS);
  assign wrStat = wrPend_ff && (wrAddr_ff == EVT_STAT_OFS);
  assign wrMask = wrPend_ff && (wrAddr_ff == EVT_MASK_OFS);

  always_comb begin
    nxt_hrdata = 32'h0;
    if (!(addrPhase && !hwrite)) begin
      nxt_hrdata = 32'h0;
    end else if (rdAddr == TB0_CTRL_OFS) begin
      nxt_hrdata = {24'h0, tb0Ctrl_ff[PERIOD_W], 4'h0, tb0Ctrl_ff[PERIOD_W-1:0]};
    end else if (rdAddr == TB1_CTRL_OFS) begin
      nxt_hrdata = {24'h0, tb1Ctrl_ff[PERIOD_W], 4'h0, tb1Ctrl_ff[PERIOD_W-1:0]};
    end else if (rdAddr == PSC_SEL_OFS) begin
      nxt_hrdata = {30'h0, pscSel_ff};
    end else if (rdAddr == INT_CTRL_OFS) begin
      nxt_hrdata = {26'h0, intCtrl_ff};
    end else if (rdAddr == FLAGS_OFS) begin
      nxt_hrdata = {29'h0, flags_ff};
    end else if (rdAddr == EVT_STAT_OFS) begin
      nxt_hrdata = {28'h0, evtStatus_ff};
    end else if (rdAddr == EVT_MASK_OFS) begin
      nxt_hrdata = {28'h0, evtMask_ff};
    end
  end

  // service arbitration, external first then time base 0 then 1
  assign enables = {intCtrl_ff[TB1_IE_BIT], intCtrl_ff[TB0_IE_BIT], intCtrl_ff[EXT_IE_BIT]};
  assign pending = flags_ff & enables;
  assign take = intCtrl_ff[GIE_BIT] && instrBoundary && !stackFull && (|pending) && !irqEntry_ff;
  assign takeSel = pending[FLG_EXT] ? 2'(FLG_EXT) : pending[FLG_TB0] ? 2'(FLG_TB0) : 2'(FLG_TB1);
  assign serviceClr = take ? NUM_FLAGS'(3'h1 << takeSel) : '0;
  assign flagSet = {tb1Ovf, tb0Ovf, extEdge};
  // wake-up looks at a flag rising, whatever its enable
  assign flagRise = flags_ff & ~flagsPrev_ff;
  assign evtSet = {sleepMode && (|flagRise), tb1Ovf, tb0Ovf, extEdge};
  // plain return keeps the global enable as it stands, cleared inside a routine
  assign plainExit = subroutineExitOp && !interruptExitOp;

  // control registers keep only enable and period; bits 6 to 3 read zero
  assign nxt_tb0Ctrl = wrTb0 ? {hwdata[TB_EN_BIT], hwdata[PERIOD_W-1:0]} : tb0Ctrl_ff;
  assign nxt_tb1Ctrl = wrTb1 ? {hwdata[TB_EN_BIT], hwdata[PERIOD_W-1:0]} : tb1Ctrl_ff;
  assign nxt_pscSel = wrPsc ? hwdata[1:0] : pscSel_ff;
  assign nxt_evtMask = wrMask ? hwdata[NUM_EVTS-1:0] : evtMask_ff;
  assign nxt_evtStatus = (evtStatus_ff & ~(wrStat ? hwdata[NUM_EVTS-1:0] : '0)) | evtSet;
  // software write loads the flags, service clears, hardware set wins
  assign nxt_flags = (((wrFlags ? hwdata[NUM_FLAGS-1:0] : flags_ff)) & ~serviceClr) | flagSet;

  // entry clears the global enable last, so it wins over an exit in the same cycle
  always_comb begin
    nxt_intCtrl = wrInt ? hwdata[5:0] : intCtrl_ff;
    if (interruptExitOp) begin
      nxt_intCtrl[GIE_BIT] = 1'b1;
    end
    if (plainExit) begin
      nxt_intCtrl[GIE_BIT] = intCtrl_ff[GIE_BIT];
    end
    if (take) begin
      nxt_intCtrl[GIE_BIT] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tb0Ctrl_ff <= {TB_CTRL_RST[TB_EN_BIT], TB_CTRL_RST[PERIOD_W-1:0]};
      tb1Ctrl_ff <= {TB_CTRL_RST[TB_EN_BIT], TB_CTRL_RST[PERIOD_W-1:0]};
      pscSel_ff <= PSC_SEL_RST;
      intCtrl_ff <= INT_CTRL_RST;
      flags_ff <= FLAGS_RST;
      flagsPrev_ff <= FLAGS_RST;
      evtStatus_ff <= EVT_RST;
      evtMask_ff <= EVT_RST;
    end else begin
      tb0Ctrl_ff <= nxt_tb0Ctrl;
      tb1Ctrl_ff <= nxt_tb1Ctrl;
      pscSel_ff <= nxt_pscSel;
      intCtrl_ff <= nxt_intCtrl;
      flags_ff <= nxt_flags;
      flagsPrev_ff <= flags_ff;
      evtStatus_ff <= nxt_evtStatus;
      evtMask_ff <= nxt_evtMask;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div4_ff <= 2'h0;
      subPrev_ff <= 1'b0;
      extPrev_ff <= 1'b0;
    end else begin
      div4_ff <= div4_ff + 2'h1;
      subPrev_ff <= subSync;
      extPrev_ff <= extSync;
    end
  end

  // bus slave, zero wait, always okay
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wrPend_ff <= 1'b0;
      wrAddr_ff <= 8'h00;
      hreadyout_ff <= 1'b0;
      hrdata_ff <= 32'h0;
    end else begin
      wrPend_ff <= addrPhase && hwrite;
      wrAddr_ff <= haddr[7:0];
      hreadyout_ff <= 1'b1;
      hrdata_ff <= nxt_hrdata;
    end
  end

  // core side outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irqEntry_ff <= 1'b0;
      irqVector_ff <= 2'h0;
      stackPush_ff <= 1'b0;
      stackPushData_ff <= '0;
      wakeUp_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      irqEntry_ff <= take;
      irqVector_ff <= take ? takeSel : irqVector_ff;
      stackPush_ff <= take;
      stackPushData_ff <= take ? pcNow : stackPushData_ff;
      wakeUp_ff <= sleepMode && (|flagRise);
      irq_ff <= |(evtStatus_ff & evtMask_ff);
    end
  end

  assign hreadyout = hreadyout_ff;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign irqEntry = irqEntry_ff;
  assign irqVector = irqVector_ff;
  assign stackPush = stackPush_ff;
  assign stackPushData = stackPushData_ff;
  assign wakeUp = wakeUp_ff;
  assign irq = irq_ff;
endmodule

// ===== tb/time_base_irq_sva.sv
// checker for the time base and interrupt block
// assumes it is bound to time_base_irq_wakeup
`timescale 1ns/1ps
module time_base_irq_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // watched signals
  input wire logic instrBoundary,
  input wire logic stackFull,
  input wire logic [time_base_irq_pkg::PC_W-1:0] pcNow,
  input wire logic interruptExitOp,
  input wire logic sleepMode,
  input wire logic irqEntry,
  input wire logic [1:0] irqVector,
  input wire logic stackPush,
  input wire logic [time_base_irq_pkg::PC_W-1:0] stackPushData,
  input wire logic wakeUp,
  input wire logic hresp
);
  import time_base_irq_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_push_with_entry: assert property (irqEntry == stackPush)
    else $error("push and entry differ");
  a_push_pc_value: assert property (irqEntry |-> stackPushData == $past(pcNow))
    else $error("pushed value is not the pc");
  a_entry_one_cycle: assert property (irqEntry |=> !irqEntry)
    else $error("entry longer than one cycle");
  a_entry_needs_room: assert property (irqEntry |-> !$past(stackFull) && $past(instrBoundary))
    else $error("entry while stack full");
  a_no_nested_entry: assert property (irqEntry ##1 (!interruptExitOp)[*3] |=> !irqEntry)
    else $error("entry without global enable");
  a_vector_known: assert property (irqEntry |-> irqVector != 2'h3)
    else $error("bad vector");
  a_wake_in_sleep: assert property (wakeUp |-> $past(sleepMode))
    else $error("wake while awake");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  c_tb0_entry: cover property (irqEntry && irqVector == 2'h1);
  c_tb1_entry: cover property (irqEntry && irqVector == 2'h2);
  c_wake: cover property (wakeUp);
endmodule

bind time_base_irq_wakeup time_base_irq_sva i_sva (.ref_clk(ref_clk), .rst(rst), .instrBoundary(instrBoundary),
  .stackFull(stackFull), .pcNow(pcNow), .interruptExitOp(interruptExitOp), .sleepMode(sleepMode),
  .irqEntry(irqEntry), .irqVector(irqVector), .stackPush(stackPush), .stackPushData(stackPushData),
  .wakeUp(wakeUp), .hresp(hresp));

// ===== tb/core_model.sv
// stand-in for the core: returns from each entry a few cycles later when exitKind is 1 or 2
// assumes exitKind 1 gives the interrupt exit, 2 the plain return, 0 none
`timescale 1ns/1ps
module core_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bench control
  input wire logic [1:0] exitKind,
  input wire logic stackFullReq,
  // block side
  input wire logic irqEntry,
  output logic instrBoundary,
  output logic stackFull,
  output logic [time_base_irq_pkg::PC_W-1:0] pcNow,
  output logic interruptExitOp,
  output logic subroutineExitOp
);
  import time_base_irq_pkg::*;
  logic [2:0] svcCnt;
  assign instrBoundary = 1'b1;
  assign stackFull = stackFullReq;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pcNow <= '0;
      svcCnt <= 3'h0;
      interruptExitOp <= 1'b0;
      subroutineExitOp <= 1'b0;
    end else begin
      pcNow <= pcNow + 1'b1;
      svcCnt <= irqEntry ? 3'h4 : svcCnt - {2'h0, svcCnt != 3'h0};
      interruptExitOp <= svcCnt == 3'h1 && exitKind == 2'h1;
      subroutineExitOp <= svcCnt == 3'h1 && exitKind == 2'h2;
    end
  end
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the time base and interrupt block
// assumes one AHB-Lite master and the core stand-in
`timescale 1ns/1ps
module tb_top;
  import time_base_irq_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, extIntPin = 1'b0, subClkPin = 1'b0, sleepMode = 1'b0, stackFullReq = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = '0, irqVector, exitKind = '0;
  logic hreadyout, hresp, instrBoundary, stackFull, interruptExitOp, subroutineExitOp, irqEntry, stackPush;
  logic wakeUp, irq;
  logic [PC_W-1:0] pcNow, stackPushData;
  int cyc, lastAt, lastGap, nEntry, nWake, bad_count, n_checks;
  always #10 ref_clk = ~ref_clk;
  time_base_irq_wakeup i_dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .extIntPin(extIntPin), .subClkPin(subClkPin), .sleepMode(sleepMode),
    .instrBoundary(instrBoundary), .stackFull(stackFull), .pcNow(pcNow), .interruptExitOp(interruptExitOp),
    .subroutineExitOp(subroutineExitOp), .irqEntry(irqEntry), .irqVector(irqVector), .stackPush(stackPush),
    .stackPushData(stackPushData), .wakeUp(wakeUp), .irq(irq));
  core_model i_core (.ref_clk(ref_clk), .rst(rst), .exitKind(exitKind), .stackFullReq(stackFullReq),
    .irqEntry(irqEntry), .instrBoundary(instrBoundary), .stackFull(stackFull), .pcNow(pcNow),
    .interruptExitOp(interruptExitOp), .subroutineExitOp(subroutineExitOp));
  // entry spacing, wake counts and a sub clock of eight cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) subClkPin <= ~subClkPin;
    if (wakeUp === 1'b1) nWake <= nWake + 1;
    if (irqEntry === 1'b1) begin
      lastGap <= cyc - lastAt;
      lastAt <= cyc;
      nEntry <= nEntry + 1;
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic isWr, input logic [31:0] wd, output logic [31:0] rdData);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= isWr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rdData = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    xfer(a, 1'b1, d, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    xfer(a, 1'b0, 32'h0, v);
    chk($sformatf("reg %h", a), exp, v);
  endtask
  task automatic gap(input logic [31:0] exp);
    int k;
    k = nEntry;
    wait (nEntry >= k + 2);
    #1;
    chk("entry gap", exp, lastGap);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #(90000 * 20);
    bad_count++;
    stop_test();
  end
  initial begin
    int k;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rd(TB0_CTRL_OFS, TB_CTRL_RST);
    rd(TB1_CTRL_OFS, TB_CTRL_RST);
    wr(TB0_CTRL_OFS, 32'h7f);
    rd(TB0_CTRL_OFS, 32'h07);
    wr(TB1_CTRL_OFS, 32'hff);
    rd(TB1_CTRL_OFS, 32'h87);
    wr(TB1_CTRL_OFS, 32'h0);
    rd(8'h40, 32'h0);
    wr(INT_CTRL_OFS, 32'h3);
    exitKind <= 2'h1;
    for (int n = 0; n < 4; n++) begin
      wr(TB0_CTRL_OFS, 32'h80 | n);
      gap(32'h1 << (8 + n));
    end
    wr(TB0_CTRL_OFS, 32'h0);
    repeat (10) @(posedge ref_clk);
    k = nEntry;
    repeat (600) @(posedge ref_clk);
    chk("entries", k, nEntry);
    wr(PSC_SEL_OFS, 32'h1);
    wr(TB0_CTRL_OFS, 32'h80);
    gap(32'd1024);
    wr(PSC_SEL_OFS, 32'h2);
    gap(32'd2048);
    wr(PSC_SEL_OFS, 32'h3);
    gap(32'd2048);
    wr(TB0_CTRL_OFS, 32'h0);
    wr(PSC_SEL_OFS, 32'h0);
    wr(INT_CTRL_OFS, 32'h5);
    wr(TB1_CTRL_OFS, 32'h86);
    gap(32'd16384);
    chk("vector", 32'h2, irqVector);
    wr(TB1_CTRL_OFS, 32'h0);
    stackFullReq <= 1'b1;
    wr(INT_CTRL_OFS, 32'h3);
    wr(TB0_CTRL_OFS, 32'h80);
    repeat (300) @(posedge ref_clk);
    k = nEntry;
    rd(FLAGS_OFS, 32'h2);
    stackFullReq <= 1'b0;
    repeat (5) @(posedge ref_clk);
    chk("entries", k + 1, nEntry);
    rd(FLAGS_OFS, 32'h0);
    exitKind <= 2'h2;
    k = nEntry;
    wait (nEntry == k + 1);
    repeat (10) @(posedge ref_clk);
    rd(INT_CTRL_OFS, 32'h2);
    repeat (300) @(posedge ref_clk);
    chk("entries", k + 1, nEntry);
    rd(FLAGS_OFS, 32'h2);
    exitKind <= 2'h1;
    wr(INT_CTRL_OFS, 32'h0);
    wr(TB0_CTRL_OFS, 32'h0);
    wr(FLAGS_OFS, 32'h0);
    wr(EVT_STAT_OFS, 32'hf);
    wr(TB0_CTRL_OFS, 32'h80);
    sleepMode <= 1'b1;
    k = nWake;
    repeat (300) @(posedge ref_clk);
    chk("wakes", k + 1, nWake);
    rd(EVT_STAT_OFS, 32'ha);
    chk("irq", 32'h0, irq);
    wr(EVT_MASK_OFS, 32'h8);
    repeat (2) @(posedge ref_clk);
    chk("irq", 32'h1, irq);
    wr(EVT_STAT_OFS, 32'h8);
    repeat (2) @(posedge ref_clk);
    chk("irq", 32'h0, irq);
    sleepMode <= 1'b0;
    wr(FLAGS_OFS, 32'h0);
    wr(FLAGS_OFS, 32'h2);
    repeat (2) @(posedge ref_clk);
    sleepMode <= 1'b1;
    k = nWake;
    repeat (600) @(posedge ref_clk);
    chk("wakes", k, nWake);
    wr(INT_CTRL_OFS, 32'h10);
    extIntPin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("wakes", k + 1, nWake);
    rd(FLAGS_OFS, 32'h3);
    wr(TB0_CTRL_OFS, 32'h0);
    wr(INT_CTRL_OFS, 32'h20);
    wr(FLAGS_OFS, 32'h0);
    extIntPin <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk("wakes", k + 2, nWake);
    rd(FLAGS_OFS, 32'h1);
    stop_test();
  end
endmodule
